// ---- verilog/usb_dma_pkg.sv ----
// constants and types shared by the endpoint receive dma
package usb_dma_pkg;
   localparam int DATA_W = 8;
   localparam int SIZE_W = 16;
   localparam int ADDR_W = 32;
   localparam int FIFO_DEPTH = 8;
   localparam logic [SIZE_W-1:0] SIZE_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
   localparam logic [SIZE_W-1:0] CNT_STEP = 16'h0001;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0001;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ACTIVE = 2'h1,
      ST_DONE = 2'h3
   } dma_state_t;
endpackage : usb_dma_pkg

// ---- verilog/rx_fifo.sv ----
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module rx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << PW) != DEPTH) begin
         $error("rx_fifo depth must be a power of two, at least 2");
      end
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW:0] wr;
      logic [PW:0] rd;
   } fifo_state_t;

   fifo_state_t s_ff;
   fifo_state_t nxt_s;
   logic full;
   logic empty;

   assign full = (s_ff.wr[PW] != s_ff.rd[PW]) && (s_ff.wr[PW-1:0] == s_ff.rd[PW-1:0]);
   assign empty = (s_ff.wr == s_ff.rd);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = s_ff.mem[s_ff.rd[PW-1:0]];

   always_comb begin
      nxt_s = s_ff;
      if (in_valid_i && !full) begin
         nxt_s.mem[s_ff.wr[PW-1:0]] = in_data_i;
         nxt_s.wr = s_ff.wr + 1'b1;
      end
      if (out_ready_i && !empty) begin
         nxt_s.rd = s_ff.rd + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule : rx_fifo

// ---- verilog/usb_endpoint_dma.sv ----
// receive-side endpoint dma with aggregated and per-packet interrupt modes
`timescale 1ns/1ps
// Overview of operation
// - size setting defines next aggregated transfer length
// - new packet accepted only when fifo empty
// - aggregated mode: one interrupt per transfer
// - per-packet mode: interrupt every packet
// - isochronous forces per-packet interrupts
module usb_endpoint_dma #(
   parameter int DATA_W = usb_dma_pkg::DATA_W,
   parameter int SIZE_W = usb_dma_pkg::SIZE_W,
   parameter int ADDR_W = usb_dma_pkg::ADDR_W,
   parameter int FIFO_DEPTH = usb_dma_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // software setup
   input wire logic start_i,
   input wire logic agg_mode_i,
   input wire logic iso_i,
   input wire logic [usb_dma_pkg::SIZE_W-1:0] xfer_size_i,
   input wire logic [usb_dma_pkg::ADDR_W-1:0] base_addr_i,
   // status
   output logic irq_o,
   output logic busy_o,
   output logic done_o,
   output logic [usb_dma_pkg::SIZE_W-1:0] byte_count_o,
   // received packet stream from usb side
   input wire logic usb_valid_i,
   output logic usb_ready_o,
   input wire logic [usb_dma_pkg::DATA_W-1:0] usb_data_i,
   input wire logic usb_last_i,
   // memory write port
   output logic mem_valid_o,
   input wire logic mem_ready_i,
   output logic [usb_dma_pkg::ADDR_W-1:0] mem_addr_o,
   output logic [usb_dma_pkg::DATA_W-1:0] mem_data_o
);
   import usb_dma_pkg::*;

   initial begin
      if (DATA_W != usb_dma_pkg::DATA_W || SIZE_W != usb_dma_pkg::SIZE_W
          || ADDR_W != usb_dma_pkg::ADDR_W || FIFO_DEPTH < 2) begin
         $error("usb_endpoint_dma parameters not supported");
      end
   end

   typedef struct packed {
      dma_state_t st;
      logic agg;
      logic [SIZE_W-1:0] size;
      logic [SIZE_W-1:0] cnt;
      logic [ADDR_W-1:0] addr;
      logic in_pkt;
      logic irq;
      logic mem_valid;
      logic [DATA_W-1:0] mem_data;
      logic [ADDR_W-1:0] mem_addr;
      logic mem_last;
   } dma_regs_t;

   dma_regs_t s_ff;
   dma_regs_t nxt_s;

   logic f_in_ready;
   logic f_out_valid;
   logic f_out_ready;
   logic [DATA_W:0] f_out_data;
   logic push;
   logic pop;
   logic mem_hs;
   logic fin;
   logic active;

   function automatic logic [SIZE_W-1:0] cnt_inc(input logic [SIZE_W-1:0] c);
      cnt_inc = c + CNT_STEP;
   endfunction : cnt_inc

   rx_fifo #(
      .WIDTH(DATA_W + 1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(push),
      .in_ready_o(f_in_ready),
      .in_data_i({usb_last_i, usb_data_i}),
      .out_valid_o(f_out_valid),
      .out_ready_i(f_out_ready),
      .out_data_o(f_out_data)
   );

   assign active = (s_ff.st == ST_ACTIVE);
   // new packet only into an empty fifo
   assign usb_ready_o = active && f_in_ready && (s_ff.in_pkt || !f_out_valid);
   assign push = usb_valid_i && usb_ready_o;
   assign mem_hs = s_ff.mem_valid && mem_ready_i;
   assign fin = mem_hs && s_ff.agg && (cnt_inc(s_ff.cnt) == s_ff.size);
   assign f_out_ready = active && (!s_ff.mem_valid || mem_ready_i) && !fin;
   assign pop = f_out_ready && f_out_valid;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.irq = 1'b0;
      case (s_ff.st)
         ST_IDLE, ST_DONE: begin
            if (start_i) begin
               nxt_s.st = ST_ACTIVE;
               nxt_s.agg = agg_mode_i && !iso_i;
               nxt_s.size = xfer_size_i;
               nxt_s.cnt = SIZE_RST;
               nxt_s.addr = base_addr_i;
               nxt_s.in_pkt = 1'b0;
            end
         end
         default: begin
         end
      endcase
      if (push) begin
         nxt_s.in_pkt = !usb_last_i;
      end
      if (mem_hs) begin
         nxt_s.mem_valid = 1'b0;
         nxt_s.cnt = cnt_inc(s_ff.cnt);
         if (fin) begin
            nxt_s.irq = 1'b1;
            nxt_s.st = ST_DONE;
         end else if (!s_ff.agg && s_ff.mem_last) begin
            nxt_s.irq = 1'b1;
         end
      end
      if (pop) begin
         nxt_s.mem_valid = 1'b1;
         nxt_s.mem_data = f_out_data[DATA_W-1:0];
         nxt_s.mem_last = f_out_data[DATA_W];
         nxt_s.mem_addr = s_ff.addr;
         nxt_s.addr = s_ff.addr + ADDR_STEP;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_ff <= '{st: ST_IDLE, size: SIZE_RST, cnt: SIZE_RST, addr: ADDR_RST,
                   mem_addr: ADDR_RST, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign irq_o = s_ff.irq;
   assign busy_o = active;
   assign done_o = (s_ff.st == ST_DONE);
   assign byte_count_o = s_ff.cnt;
   assign mem_valid_o = s_ff.mem_valid;
   assign mem_addr_o = s_ff.mem_addr;
   assign mem_data_o = s_ff.mem_data;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence arm_s;
      start_i && !active;
   endsequence

   sequence pkt_end_s;
      active && mem_hs && !s_ff.agg && s_ff.mem_last;
   endsequence

   sequence word_wait_s;
      mem_valid_o && !mem_ready_i;
   endsequence

   sequence word_step_s;
      pop && s_ff.mem_valid;
   endsequence

   sequence pkt_mode_s;
      active && !s_ff.agg;
   endsequence

   size_latch_a: assert property (arm_s |=> s_ff.size == $past(xfer_size_i)
      && s_ff.cnt == SIZE_RST && active)
      else $error("size not latched at arm");
   accept_empty_a: assert property (push && !s_ff.in_pkt |-> !f_out_valid)
      else $error("packet start accepted with fifo not empty");
   agg_done_irq_a: assert property (fin |=> irq_o && done_o ##1 !irq_o)
      else $error("aggregated completion interrupt wrong");
   agg_mid_irq_a: assert property (irq_o && $past(s_ff.agg) |-> done_o)
      else $error("aggregated interrupt before completion");
   pkt_irq_a: assert property (pkt_end_s |=> irq_o)
      else $error("missing per-packet interrupt");
   iso_mode_a: assert property (arm_s ##0 iso_i |=> !s_ff.agg)
      else $error("isochronous armed in aggregated mode");
   done_wait_a: assert property (done_o && !start_i |=> done_o && !usb_ready_o
      && s_ff.cnt == s_ff.size)
      else $error("done state not held");
   word_hold_a: assert property (word_wait_s |=> mem_valid_o
      && $stable(mem_addr_o) && $stable(mem_data_o))
      else $error("memory write changed before acceptance");
   addr_step_a: assert property (word_step_s |=>
      mem_addr_o == $past(mem_addr_o) + ADDR_STEP)
      else $error("memory address not stepped by one");
   irq_pulse_a: assert property (irq_o |=> !irq_o)
      else $error("interrupt longer than one cycle");
   irq_cause_a: assert property (irq_o |-> $past(mem_hs))
      else $error("interrupt without memory write");
   pkt_stay_a: assert property (pkt_mode_s |=> active)
      else $error("per-packet transfer left active state");
   idle_quiet_a: assert property (!active |-> !usb_ready_o && !mem_valid_o)
      else $error("traffic outside active state");
   size_hold_a: assert property (active |=> $stable(s_ff.size))
      else $error("transfer size changed during transfer");
   agg_cnt_a: assert property (active && s_ff.agg && s_ff.size != SIZE_RST
      |-> s_ff.cnt < s_ff.size)
      else $error("aggregated count passed programmed size");
   cnt_step_a: assert property (mem_hs |=>
      byte_count_o == $past(byte_count_o) + CNT_STEP)
      else $error("byte count not stepped per write");
endmodule : usb_endpoint_dma

// ---- verif/usb_host_model.sv ----
// usb host model feeding packets to the endpoint
`timescale 1ns/1ps
module usb_host_model (
   // clock
   input wire logic clk_i,
   // packet stream
   input wire logic ready_i,
   output logic valid_o,
   output logic [usb_dma_pkg::DATA_W-1:0] data_o,
   output logic last_o
);
   int gap = 0;
   initial begin
      valid_o = 1'b0;
      data_o = 8'hFF;
      last_o = 1'b0;
   end
   task automatic send(input logic [7:0] first, input int len);
      for (int i = 0; i < len; i++) begin
         @(negedge clk_i);
         valid_o = 1'b1;
         data_o = first + i[7:0];
         last_o = (i == len - 1);
         do @(posedge clk_i); while (ready_i !== 1'b1);
         if (gap > 0) begin
            @(negedge clk_i);
            valid_o = 1'b0;
            data_o = ~data_o;
            repeat (gap - 1) @(negedge clk_i);
         end
      end
      @(negedge clk_i);
      valid_o = 1'b0;
      data_o = ~data_o;
      last_o = 1'b0;
   endtask : send
endmodule : usb_host_model

// ---- verif/usb_endpoint_dma_tb.sv ----
// self-checking bench for the endpoint receive dma
`timescale 1ns/1ps
module usb_endpoint_dma_tb;
   import usb_dma_pkg::*;
   logic clk_i = 1'b0, reset_n_i = 1'b0, start_i = 1'b0, agg_mode_i = 1'b0, iso_i = 1'b0;
   logic mem_ready_i = 1'b1, stall = 1'b0;
   logic [SIZE_W-1:0] xfer_size_i = SIZE_RST;
   logic [ADDR_W-1:0] base_addr_i = ADDR_RST, exp_addr, mem_addr_o;
   logic irq_o, busy_o, done_o, mem_valid_o, usb_valid_i, usb_ready_o, usb_last_i;
   logic [SIZE_W-1:0] byte_count_o;
   logic [DATA_W-1:0] usb_data_i, mem_data_o, exp_data;
   int n_errors = 0, compares = 0, n_irq = 0, n_wr = 0, cycles = 0;
   always #5 clk_i = ~clk_i;
   usb_endpoint_dma dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i),
      .agg_mode_i(agg_mode_i), .iso_i(iso_i), .xfer_size_i(xfer_size_i),
      .base_addr_i(base_addr_i), .irq_o(irq_o), .busy_o(busy_o), .done_o(done_o),
      .byte_count_o(byte_count_o), .usb_valid_i(usb_valid_i), .usb_ready_o(usb_ready_o),
      .usb_data_i(usb_data_i), .usb_last_i(usb_last_i), .mem_valid_o(mem_valid_o),
      .mem_ready_i(mem_ready_i), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o));
   usb_host_model host_u (.clk_i(clk_i), .ready_i(usb_ready_o), .valid_o(usb_valid_i),
      .data_o(usb_data_i), .last_o(usb_last_i));
   task automatic summarize;
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   always @(posedge clk_i) begin
      cycles++;
      if (irq_o === 1'b1) n_irq++;
      if (mem_valid_o === 1'b1 && mem_ready_i === 1'b1) begin
         chk(mem_addr_o, exp_addr);
         chk({24'h0, mem_data_o}, {24'h0, exp_data});
         exp_addr++;
         exp_data++;
         n_wr++;
      end
      if (cycles == 3000) begin
         n_errors++;
         summarize();
      end
   end
   always @(negedge clk_i) mem_ready_i <= stall ? ~mem_ready_i : 1'b1;
   task automatic do_reset;
      @(negedge clk_i);
      reset_n_i = 1'b0;
      repeat (2) @(negedge clk_i);
      reset_n_i = 1'b1;
   endtask : do_reset
   task automatic arm(input logic agg, iso, input logic [15:0] size, input logic [31:0] base);
      @(negedge clk_i);
      start_i = 1'b1;
      agg_mode_i = agg;
      iso_i = iso;
      xfer_size_i = size;
      base_addr_i = base;
      exp_addr = base;
      n_irq = 0;
      n_wr = 0;
      @(negedge clk_i);
      start_i = 1'b0;
      chk(busy_o, 32'h1);
   endtask : arm
   task automatic wait_wr(input int n);
      while (n_wr < n) @(posedge clk_i);
      repeat (4) @(negedge clk_i);
   endtask : wait_wr
   task automatic test_agg;
      stall = 1'b1;
      arm(1'b1, 1'b0, 16'h0004, 32'h100);
      exp_data = 8'h10;
      host_u.send(8'h10, 2);
      host_u.send(8'h12, 2);
      wait_wr(4);
      chk(n_irq, 32'h1);
      chk(done_o, 32'h1);
      chk(busy_o, 32'h0);
      chk(byte_count_o, 32'h4);
      arm(1'b1, 1'b0, 16'h0003, 32'h180);
      exp_data = 8'h20;
      host_u.gap = 2;
      host_u.send(8'h20, 3);
      wait_wr(3);
      chk(n_irq, 32'h1);
      chk(byte_count_o, 32'h3);
      chk(done_o, 32'h1);
      $display("test_agg finished");
   endtask : test_agg
   task automatic test_pkt(input logic agg, iso);
      do_reset();
      stall = 1'b0;
      host_u.gap = 0;
      arm(agg, iso, 16'h0002, 32'h200);
      exp_data = 8'h40;
      host_u.send(8'h40, 3);
      host_u.send(8'h43, 1);
      wait_wr(4);
      chk(n_irq, 32'h2);
      chk(busy_o, 32'h1);
      chk(done_o, 32'h0);
      $display("test_pkt agg=%b iso=%b finished", agg, iso);
   endtask : test_pkt
   initial begin
      do_reset();
      test_agg();
      test_pkt(1'b0, 1'b0);
      test_pkt(1'b1, 1'b1);
      summarize();
   end
endmodule : usb_endpoint_dma_tb
